// *** hdl/qaw_watchdog.sv ***
// question-and-answer watchdog, device end
// Notes on behaviour
// - mode 0: four answers over two windows
// - mode 1: one answer in open window
// - pending question readable in question register
// - host computes and writes answers to answer register
// - multi set good only if values, order, windows
// - single answer good only if value, open window
// - early, late, wrong or misordered answers are wrong
// - no answer: time-out flag, count up, restart
// - change of mode bit, window or answer setting counts up and restarts sequence
// - reset-enable bit resets to one
// - counter down on correct, up on wrong
// - counter moves only in diag, active, safe
// - below drive threshold: safing output high
// - safing output needs driver enable bit
// - at or above threshold: safing output low
// - host resyncs via time-out or config rewrite
// - counter saturates at 0xF and 0x0
// - counter resets to 0x05
// - reset enabled and threshold reached: reset low
// - window lasts (field+1) times one step
`timescale 1ns/1ps
module qaw_watchdog
  import qaw_pkg::*;
#(
  parameter int STEP_CYC = QAW_STEP_CYC
) (
  input  wire logic           CLK,
  input  wire logic           RST,
  qaw_link_if.dev             LINK,
  input  wire qaw_dev_state_e DEV_STATE,
  output logic [3:0]          FAIL_COUNT,
  output logic                SEQ_START
);
  localparam int SW = $clog2(STEP_CYC + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);

  typedef struct packed {
    logic [7:0]    cfg3;
    logic [7:0]    cfg4;
    logic [7:0]    win1;
    logic [7:0]    win2;
    logic [7:0]    qacfg;
    logic [7:0]    ctrl;
    logic [3:0]    question;
    logic [3:0]    fcnt;
    logic [1:0]    ans_cnt;
    logic          bad;
    logic          phase2;
    logic [SW-1:0] step;
    logic [7:0]    wstep;
    logic [2:0]    status;
    logic [7:0]    rdata;
    logic          rvalid;
    logic          safing;
    logic          rst_n;
    logic          seq_start;
  } qaw_dev_s;

  qaw_dev_s st_q;
  qaw_dev_s st_d;

  // saturating counter step
  function automatic logic [3:0] sat_step(input logic [3:0] c, input logic up);
    if (up) begin
      return (c == QAW_FCNT_MAX) ? c : c + 4'h1;
    end
    return (c == QAW_FCNT_MIN) ? c : c - 4'h1;
  endfunction : sat_step

  logic       mode_single;
  logic       wr_ans;
  logic       cfg_chg;
  logic       win_end;
  logic       finish;
  logic       ans_ok;
  logic       in_win;
  logic       timeout;
  logic       counting;
  logic [7:0] limit;
  logic       inc_a;
  logic       dec_a;
  logic       inc_b;
  logic [3:0] cnt_a;
  logic [3:0] cnt_b;
  logic [2:0] sets;

  always_comb begin
    st_d        = st_q;
    sets        = 3'h0;
    mode_single = st_q.cfg3[QAW_CFG3_MODE_BIT];
    wr_ans      = LINK.wr && (LINK.addr == QAW_ADDR_ANSWER);
    counting    = (DEV_STATE != QAW_DS_OTHER);
    // window timing in steps
    limit = st_q.phase2 ? {3'h0, st_q.win2[4:0]} : st_q.win1;
    win_end = (st_q.step == STEP_LAST) && (st_q.wstep == limit);
    // writes that change the mode bit, a window length or the answer setting
    cfg_chg = LINK.wr && (
      ((LINK.addr == QAW_ADDR_CFG3) &&
       (LINK.wdata[QAW_CFG3_MODE_BIT] != st_q.cfg3[QAW_CFG3_MODE_BIT])) ||
      ((LINK.addr == QAW_ADDR_WIN1) && (LINK.wdata != st_q.win1)) ||
      ((LINK.addr == QAW_ADDR_WIN2) && (LINK.wdata[4:0] != st_q.win2[4:0])) ||
      ((LINK.addr == QAW_ADDR_QACFG) && (LINK.wdata != st_q.qacfg)));
    // judging an answer
    ans_ok = (LINK.wdata == qaw_answer(st_q.question, st_q.qacfg, st_q.ans_cnt));
    if (mode_single) begin
      in_win = st_q.phase2;
      finish = wr_ans;
    end else begin
      in_win = (st_q.ans_cnt == 2'h0) ? st_q.phase2 : !st_q.phase2;
      finish = wr_ans && (st_q.ans_cnt == 2'h0);
    end
    timeout = win_end && st_q.phase2 && !finish;
    if (wr_ans) begin
      st_d.bad = st_q.bad || !ans_ok || !in_win;
      if (!mode_single) begin
        st_d.ans_cnt = st_q.ans_cnt - 2'h1;
      end
    end
    // counter events, applied one at a time
    inc_a = (finish && (st_q.bad || !ans_ok || !in_win)) || timeout;
    dec_a = finish && !(st_q.bad || !ans_ok || !in_win);
    inc_b = cfg_chg;
    cnt_a = (inc_a || dec_a) ? sat_step(st_q.fcnt, inc_a) : st_q.fcnt;
    cnt_b = inc_b ? sat_step(cnt_a, 1'b1) : cnt_a;
    if (counting) begin
      st_d.fcnt = cnt_b;
      if (inc_a || inc_b) begin
        sets[QAW_ST_FAIL_BIT] = 1'b1;
      end
      if (timeout) begin
        sets[QAW_ST_TIMEOUT_BIT] = 1'b1;
      end
      if (finish && inc_a) begin
        sets[QAW_ST_WRONG_BIT] = 1'b1;
      end
      st_d.status = st_q.status | sets;
    end
    // window stepping
    st_d.step = (st_q.step == STEP_LAST) ? '0 : st_q.step + SW'(1);
    if (st_q.step == STEP_LAST) begin
      st_d.wstep = st_q.wstep + 8'h1;
    end
    if (win_end && !st_q.phase2) begin
      st_d.phase2 = 1'b1;
      st_d.wstep  = 8'h0;
    end
    // register writes; status bits clear on one, set wins
    st_d.rvalid = 1'b0;
    if (LINK.wr) begin
      unique case (LINK.addr)
        QAW_ADDR_CFG3:  st_d.cfg3 = LINK.wdata;
        QAW_ADDR_CFG4: begin
          st_d.cfg4 = LINK.wdata;
          if (DEV_STATE == QAW_DS_DIAG) begin
            st_d.fcnt = LINK.wdata[3:0];
          end
        end
        QAW_ADDR_WIN1:  st_d.win1 = LINK.wdata;
        QAW_ADDR_WIN2:  st_d.win2 = {3'h0, LINK.wdata[4:0]};
        QAW_ADDR_QACFG: st_d.qacfg = LINK.wdata;
        QAW_ADDR_CTRL:  st_d.ctrl = LINK.wdata;
        QAW_ADDR_STATUS: begin
          st_d.status = (st_q.status & ~LINK.wdata[2:0]) | sets;
        end
        default: ;
      endcase
    end
    // register reads, answered the next cycle
    if (LINK.rd) begin
      st_d.rvalid = 1'b1;
      unique case (LINK.addr)
        QAW_ADDR_CFG3:   st_d.rdata = st_q.cfg3;
        QAW_ADDR_CFG4:   st_d.rdata = st_q.cfg4;
        QAW_ADDR_WIN1:   st_d.rdata = st_q.win1;
        QAW_ADDR_WIN2:   st_d.rdata = st_q.win2;
        QAW_ADDR_QACFG:  st_d.rdata = st_q.qacfg;
        QAW_ADDR_CTRL:   st_d.rdata = st_q.ctrl;
        QAW_ADDR_QVAL:   st_d.rdata = {4'h0, st_q.question};
        QAW_ADDR_STATUS: st_d.rdata = {3'h0, !st_q.rst_n, !st_q.safing, st_q.status};
        QAW_ADDR_FCNT:   st_d.rdata = {4'h0, st_q.fcnt};
        default:         st_d.rdata = 8'h00;
      endcase
    end
    // new sequence run
    st_d.seq_start = finish || timeout || cfg_chg;
    if (finish || timeout || cfg_chg) begin
      st_d.question = qaw_next_q(st_q.question, st_q.qacfg);
      st_d.ans_cnt  = (cfg_chg ? LINK.wdata[QAW_CFG3_MODE_BIT] && (LINK.addr == QAW_ADDR_CFG3)
                      : mode_single) ? QAW_SINGLE_CNT : QAW_MULTI_CNT;
      if (cfg_chg && (LINK.addr != QAW_ADDR_CFG3)) begin
        st_d.ans_cnt = mode_single ? QAW_SINGLE_CNT : QAW_MULTI_CNT;
      end
      st_d.bad    = 1'b0;
      st_d.phase2 = 1'b0;
      st_d.step   = '0;
      st_d.wstep  = 8'h0;
    end
    // output pins
    st_d.safing = st_q.ctrl[QAW_CTRL_DRVEN_BIT] &&
                  (st_q.fcnt < st_q.cfg4[3:0]);
    st_d.rst_n  = !(st_q.cfg3[QAW_CFG3_RSTEN_BIT] &&
                    (st_q.fcnt >= st_q.cfg4[7:4]));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q          <= '0;
      st_q.cfg3     <= QAW_CFG3_RST;
      st_q.cfg4     <= QAW_CFG4_RST;
      st_q.win1     <= QAW_WIN1_RST;
      st_q.win2     <= QAW_WIN2_RST;
      st_q.qacfg    <= QAW_QACFG_RST;
      st_q.ctrl     <= QAW_CTRL_RST;
      st_q.question <= QAW_Q_RST;
      st_q.fcnt     <= QAW_FCNT_RST;
      st_q.ans_cnt  <= QAW_MULTI_CNT;
      st_q.rst_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign LINK.rdata      = st_q.rdata;
  assign LINK.rvalid     = st_q.rvalid;
  assign LINK.safing_out = st_q.safing;
  assign LINK.mcu_rst_n  = st_q.rst_n;
  assign FAIL_COUNT      = st_q.fcnt;
  assign SEQ_START       = st_q.seq_start;
endmodule : qaw_watchdog

// *** hdl/qaw_pkg.sv ***
// constants, types and answer arithmetic shared by both watchdog ends
package qaw_pkg;
  // register indices on the frame link
  localparam logic [3:0] QAW_ADDR_CFG3   = 4'h0;
  localparam logic [3:0] QAW_ADDR_CFG4   = 4'h1;
  localparam logic [3:0] QAW_ADDR_WIN1   = 4'h2;
  localparam logic [3:0] QAW_ADDR_WIN2   = 4'h3;
  localparam logic [3:0] QAW_ADDR_QACFG  = 4'h4;
  localparam logic [3:0] QAW_ADDR_CTRL   = 4'h5;
  localparam logic [3:0] QAW_ADDR_QVAL   = 4'h6;
  localparam logic [3:0] QAW_ADDR_ANSWER = 4'h7;
  localparam logic [3:0] QAW_ADDR_STATUS = 4'h8;
  localparam logic [3:0] QAW_ADDR_FCNT   = 4'h9;
  // field positions
  localparam int QAW_CFG3_MODE_BIT  = 0;
  localparam int QAW_CFG3_RSTEN_BIT = 1;
  localparam int QAW_CTRL_DRVEN_BIT = 0;
  localparam int QAW_ST_TIMEOUT_BIT = 0;
  localparam int QAW_ST_FAIL_BIT    = 1;
  localparam int QAW_ST_WRONG_BIT   = 2;
  // reset values
  localparam logic [7:0] QAW_CFG3_RST  = 8'h02;
  localparam logic [7:0] QAW_CFG4_RST  = 8'hF5;
  localparam logic [7:0] QAW_WIN1_RST  = 8'h0F;
  localparam logic [7:0] QAW_WIN2_RST  = 8'h0F;
  localparam logic [7:0] QAW_QACFG_RST = 8'h00;
  localparam logic [7:0] QAW_CTRL_RST  = 8'h00;
  localparam logic [3:0] QAW_Q_RST     = 4'h1;
  localparam logic [3:0] QAW_FCNT_RST  = 4'h5;
  localparam logic [3:0] QAW_FCNT_MAX  = 4'hF;
  localparam logic [3:0] QAW_FCNT_MIN  = 4'h0;
  localparam logic [1:0] QAW_MULTI_CNT = 2'h3;
  localparam logic [1:0] QAW_SINGLE_CNT = 2'h1;
  // timing: one window step
  localparam int QAW_CLK_PS   = 50000;
  localparam int QAW_STEP_PS  = 550000000;
  localparam int QAW_STEP_CYC = QAW_STEP_PS / QAW_CLK_PS;

  typedef enum logic [1:0] {
    QAW_DS_DIAG,
    QAW_DS_ACTIVE,
    QAW_DS_SAFE,
    QAW_DS_OTHER
  } qaw_dev_state_e;

  // expected answer byte for a question, generation setting and answer index
  function automatic logic [7:0] qaw_answer(input logic [3:0] q, input logic [7:0] cfg,
                                            input logic [1:0] idx);
    logic [7:0] t;
    t = {q ^ cfg[7:4], ~q ^ cfg[3:0]};
    return {t[6:0], t[7]} ^ {4'h0, 2'h0, idx};
  endfunction : qaw_answer

  // next question in the sequence, never zero
  function automatic logic [3:0] qaw_next_q(input logic [3:0] q, input logic [7:0] cfg);
    logic [3:0] n;
    n = {q[2:0], q[3] ^ q[2] ^ cfg[0]};
    return (n == 4'h0) ? QAW_Q_RST : n;
  endfunction : qaw_next_q
endpackage : qaw_pkg

// *** hdl/qaw_link_if.sv ***
// frame link between the supervising watchdog and the microcontroller end
`timescale 1ns/1ps
interface qaw_link_if;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       safing_out;
  logic       mcu_rst_n;
  modport dev  (input wr, rd, addr, wdata, output rdata, rvalid, safing_out, mcu_rst_n);
  modport host (output wr, rd, addr, wdata, input rdata, rvalid, safing_out, mcu_rst_n);
endinterface : qaw_link_if

// *** hdl/qaw_mcu.sv ***
// microcontroller end: register frames and computed watchdog answers
`timescale 1ns/1ps
module qaw_mcu
  import qaw_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  qaw_link_if.host        LINK,
  input  wire logic       REQ_VALID,
  input  wire logic [1:0] REQ_KIND,
  input  wire logic [3:0] REQ_ADDR,
  input  wire logic [7:0] REQ_DATA,
  input  wire logic [1:0] REQ_IDX,
  output logic            REQ_READY,
  output logic            RSP_VALID,
  output logic [7:0]      RSP_DATA,
  output logic            SAFING_SEEN,
  output logic            MCU_RST_N_SEEN
);
  typedef enum logic [1:0] {H_IDLE, H_WAITR, H_WAITQ} qaw_host_e;

  typedef struct packed {
    qaw_host_e  fsm;
    logic [7:0] qacfg;
    logic [7:0] mask;
    logic [1:0] idx;
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       safing;
    logic       rst_n;
  } qaw_host_s;

  qaw_host_s st_q;
  qaw_host_s st_d;

  always_comb begin
    st_d           = st_q;
    st_d.wr        = 1'b0;
    st_d.rd        = 1'b0;
    st_d.rsp_valid = 1'b0;
    st_d.safing    = LINK.safing_out;
    st_d.rst_n     = LINK.mcu_rst_n;
    unique case (st_q.fsm)
      H_IDLE: begin
        if (REQ_VALID && !st_q.wr && !st_q.rd) begin
          st_d.mask = REQ_DATA;
          st_d.idx  = REQ_IDX;
          if (REQ_KIND == 2'h0) begin
            st_d.wr    = 1'b1;
            st_d.addr  = REQ_ADDR;
            st_d.wdata = REQ_DATA;
            if (REQ_ADDR == QAW_ADDR_QACFG) begin
              st_d.qacfg = REQ_DATA;
            end
          end else if (REQ_KIND == 2'h1) begin
            st_d.rd   = 1'b1;
            st_d.addr = REQ_ADDR;
            st_d.fsm  = H_WAITR;
          end else begin
            st_d.rd   = 1'b1;
            st_d.addr = QAW_ADDR_QVAL;
            st_d.fsm  = H_WAITQ;
          end
        end
      end
      H_WAITR: begin
        if (LINK.rvalid) begin
          st_d.rsp_valid = 1'b1;
          st_d.rsp_data  = LINK.rdata;
          st_d.fsm       = H_IDLE;
        end
      end
      H_WAITQ: begin
        if (LINK.rvalid) begin
          st_d.wr    = 1'b1;
          st_d.addr  = QAW_ADDR_ANSWER;
          st_d.wdata = qaw_answer(LINK.rdata[3:0], st_q.qacfg, st_q.idx) ^
                       st_q.mask;
          st_d.rsp_valid = 1'b1;
          st_d.rsp_data  = {4'h0, LINK.rdata[3:0]};
          st_d.fsm       = H_IDLE;
        end
      end
      default: st_d.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q       <= '0;
      st_q.fsm   <= H_IDLE;
      st_q.qacfg <= QAW_QACFG_RST;
      st_q.rst_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign LINK.wr        = st_q.wr;
  assign LINK.rd        = st_q.rd;
  assign LINK.addr      = st_q.addr;
  assign LINK.wdata     = st_q.wdata;
  assign REQ_READY      = (st_q.fsm == H_IDLE) && !st_q.wr && !st_q.rd;
  assign RSP_VALID      = st_q.rsp_valid;
  assign RSP_DATA       = st_q.rsp_data;
  assign SAFING_SEEN    = st_q.safing;
  assign MCU_RST_N_SEEN = st_q.rst_n;
endmodule : qaw_mcu

// *** tb/qaw_link_checker.sv ***
// concurrent checks on the frame link between the two watchdog ends
`timescale 1ns/1ps
module qaw_link_checker
  import qaw_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       safing_out,
  input wire logic       mcu_rst_n
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // shadow of the CFG3 and CFG4 bytes and the drive-enable bit written over the link
  typedef struct packed {
    logic [7:0] c3;
    logic [7:0] c4;
    logic       ctl;
  } qaw_shadow_s;
  qaw_shadow_s sh_q;
  qaw_shadow_s sh_d;
  always_comb begin
    sh_d = sh_q;
    if (wr && addr == QAW_ADDR_CFG3) sh_d.c3 = wdata;
    if (wr && addr == QAW_ADDR_CFG4) sh_d.c4 = wdata;
    if (wr && addr == QAW_ADDR_CTRL) sh_d.ctl = wdata[QAW_CTRL_DRVEN_BIT];
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      sh_q <= '{QAW_CFG3_RST, QAW_CFG4_RST, 1'b0};
    end else begin
      sh_q <= sh_d;
    end
  end
  property p_read_answer; rd |=> rvalid; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read strobe got no answer");
  property p_no_stray; rvalid |-> $past(rd); endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("read answer without read strobe");
  property p_question;
    rd && addr == QAW_ADDR_QVAL |=> rdata[7:4] == 4'h0 && rdata[3:0] != 4'h0;
  endproperty
  a_question: assert property (p_question)
    else $error("question read malformed");
  property p_strobes; !(wr && rd); endproperty
  a_strobes: assert property (p_strobes)
    else $error("write and read strobes together");
  property p_rsten_read;
    rd && addr == QAW_ADDR_CFG3 |=> rdata[QAW_CFG3_RSTEN_BIT] == sh_q.c3[QAW_CFG3_RSTEN_BIT];
  endproperty
  a_rsten_read: assert property (p_rsten_read)
    else $error("reset enable bit reads wrong");
  property p_drive_enable; safing_out |-> sh_q.ctl || $past(sh_q.ctl); endproperty
  a_drive_enable: assert property (p_drive_enable)
    else $error("safing output active without enable");
  property p_reset_enable;
    !mcu_rst_n |-> sh_q.c3[QAW_CFG3_RSTEN_BIT] || $past(sh_q.c3[QAW_CFG3_RSTEN_BIT]);
  endproperty
  a_reset_enable: assert property (p_reset_enable)
    else $error("reset output low without enable");
  property p_out_of_range;
    !mcu_rst_n && sh_q.c4[7:4] >= sh_q.c4[3:0] |-> !safing_out;
  endproperty
  a_out_of_range: assert property (p_out_of_range)
    else $error("safing output high above threshold");
endmodule : qaw_link_checker

// *** tb/qaw_watchdog_bench.sv ***
// self-checking bench joining the watchdog and microcontroller ends
`timescale 1ns/1ps
module qaw_watchdog_bench;
  import qaw_pkg::*;
  localparam int STEP = 4;
  localparam int W1   = (int'(QAW_WIN1_RST) + 1) * STEP;
  logic           CLK       = 1'b0;
  logic           RST       = 1'b1;
  logic           req_valid = 1'b0;
  logic [1:0]     req_kind  = 2'h0;
  logic [3:0]     req_addr  = 4'h0;
  logic [7:0]     req_data  = 8'h00;
  logic [1:0]     req_idx   = 2'h0;
  qaw_dev_state_e dev_state = QAW_DS_DIAG;
  logic           req_ready, rsp_valid, seq_start, safing_seen, rst_seen;
  logic [7:0]     rsp_data, rd_val;
  logic [3:0]     fail_count, fc;
  logic           ctl = 1'b0, rsten = 1'b1;
  logic [31:0]    v;
  int             seed = 80587, mismatches = 0, checked = 0, cyc = 0, t_start = 0;
  qaw_link_if link ();
  qaw_watchdog #(.STEP_CYC(STEP)) qaw_watchdog_i (.CLK(CLK), .RST(RST), .LINK(link),
    .DEV_STATE(dev_state), .FAIL_COUNT(fail_count), .SEQ_START(seq_start));
  qaw_mcu qaw_mcu_i (.CLK(CLK), .RST(RST), .LINK(link), .REQ_VALID(req_valid),
    .REQ_KIND(req_kind), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_IDX(req_idx),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .SAFING_SEEN(safing_seen), .MCU_RST_N_SEEN(rst_seen));
  qaw_link_checker qaw_link_checker_i (.CLK(CLK), .RST(RST), .wr(link.wr), .rd(link.rd),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
    .safing_out(link.safing_out), .mcu_rst_n(link.mcu_rst_n));
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (seq_start === 1'b1) t_start <= cyc;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one request to the host end; reads wait for the response byte
  task automatic req(input logic [1:0] k, input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] i);
    logic r;
    int   n;
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_data <= d;
    req_idx <= i;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge CLK);
      r = req_ready;
      @(posedge CLK);
    end
    req_valid <= 1'b0;
    n = 0;
    if (k != 2'h0) begin
      do begin
        @(negedge CLK);
        n++;
      end while (rsp_valid !== 1'b1 && n < 10);
      chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
      rd_val = rsp_data;
    end
    @(posedge CLK);
  endtask : req
  function automatic logic [3:0] step(input logic [3:0] c, input logic up);
    if (dev_state == QAW_DS_OTHER) return c;
    if (up) return (c == QAW_FCNT_MAX) ? c : c + 4'h1;
    return (c == QAW_FCNT_MIN) ? c : c - 4'h1;
  endfunction : step
  task automatic settle();
    logic sf;
    logic rn;
    sf = ctl && fc < QAW_CFG4_RST[3:0];
    rn = !(rsten && fc >= QAW_CFG4_RST[7:4]);
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    chk("fail_count", {4'h0, fc}, {4'h0, fail_count});
    chk("safing", {7'h0, sf}, {7'h0, link.safing_out});
    chk("safing_seen", {7'h0, sf}, {7'h0, safing_seen});
    chk("reset_n", {7'h0, rn}, {7'h0, link.mcu_rst_n});
    chk("reset_n_seen", {7'h0, rn}, {7'h0, rst_seen});
    @(posedge CLK);
  endtask : settle
  task automatic cfg(input logic [3:0] a, input logic [7:0] d);
    req(2'h0, a, d, 2'h0);
    fc = step(fc, 1'b1);
    settle();
  endtask : cfg
  // answer early in the run, or after the first window when late is set
  task automatic ans(input logic [1:0] i, input logic [7:0] m, input logic late,
                     input logic fin);
    while (cyc < t_start + (late ? W1 + 4 : 4)) @(posedge CLK);
    req(2'h2, QAW_ADDR_ANSWER, m, i);
    if (fin) fc = step(fc, m != 8'h00 || !late);
    settle();
  endtask : ans
  task automatic rnd_state(input logic other);
    v = $random(seed);
    if (other) dev_state <= QAW_DS_OTHER;
    else dev_state <= qaw_dev_state_e'((v[1:0] == 2'h3) ? 2'h0 : v[1:0]);
    @(posedge CLK);
  endtask : rnd_state
  // budget well above the sum of all runs
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    results();
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    fc = 4'h5;
    @(posedge CLK);
    req(2'h1, QAW_ADDR_CFG3, 8'h00, 2'h0);
    chk("reset_enable", 8'h01, {7'h0, rd_val[QAW_CFG3_RSTEN_BIT]});
    req(2'h1, QAW_ADDR_FCNT, 8'h00, 2'h0);
    chk("fcnt_reg", 8'h05, rd_val);
    settle();
    req(2'h0, QAW_ADDR_CTRL, 8'h01, 2'h0);
    ctl = 1'b1;
    settle();
    $display("test reset done");
    v = $random(seed);
    cfg(QAW_ADDR_QACFG, v[7:0] | 8'h01);
    for (int k = 0; k < 2; k++) begin
      v = $random(seed);
      for (int i = 3; i >= 0; i--) begin
        ans(2'(i), (i == 0 && k == 1) ? (v[7:0] | 8'h01) : 8'h00, i == 0, i == 0);
      end
    end
    $display("test multi done");
    cfg(QAW_ADDR_CFG3, 8'h03);
    ans(2'h1, 8'h00, 1'b1, 1'b1);
    ans(2'h1, 8'h00, 1'b0, 1'b1);
    $display("test single done");
    repeat (2 * W1 + 8) @(posedge CLK);
    fc = step(fc, 1'b1);
    settle();
    req(2'h1, QAW_ADDR_STATUS, 8'h00, 2'h0);
    chk("timeout_flag", 8'h01, {7'h0, rd_val[QAW_ST_TIMEOUT_BIT]});
    chk("fail_flag", 8'h01, {7'h0, rd_val[QAW_ST_FAIL_BIT]});
    $display("test timeout done");
    for (int k = 0; k < 14; k++) begin
      rnd_state(1'b0);
      ans(2'h1, v[15:8] | 8'h01, 1'b0, 1'b1);
    end
    req(2'h0, QAW_ADDR_CFG3, 8'h01, 2'h0);
    rsten = 1'b0;
    settle();
    $display("test saturate high done");
    for (int k = 0; k < 20; k++) begin
      rnd_state(k == 3);
      ans(2'h1, 8'h00, 1'b1, 1'b1);
    end
    $display("test saturate low done");
    results();
  end
endmodule : qaw_watchdog_bench
